// ---- rtl/dtp_map.svh ----
// Register offsets, ranges, reset values and timing of the drive tuning bank
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH
// ==========================================================================
// Holding register offsets
`define DTP_OFS_FIRST      16'h0092
`define DTP_OFS_OL_MODE    16'h0092
`define DTP_OFS_OL_LEVEL   16'h0093
`define DTP_OFS_OL_DECEL   16'h0094
`define DTP_OFS_LOCK_SEL   16'h0095
`define DTP_OFS_AM_GAIN    16'h0096
`define DTP_OFS_RESERVED   16'h0097
`define DTP_OFS_START_FRQ  16'h0098
`define DTP_OFS_CARRIER    16'h0099
`define DTP_OFS_INIT_MODE  16'h009a
`define DTP_OFS_REGION     16'h009b
`define DTP_OFS_DISP_SCALE 16'h009c
`define DTP_OFS_STOP_KEY   16'h009d
`define DTP_OFS_RESTART    16'h009e
`define DTP_OFS_BRK_RATIO  16'h009f
`define DTP_OFS_STOP_METH  16'h00a0
`define DTP_OFS_FAN_CTL    16'h00a1
`define DTP_OFS_BRK_CTL    16'h00a2
`define DTP_OFS_BRK_LEVEL  16'h00a3
`define DTP_OFS_LAST       16'h00a3
// ==========================================================================
// Accepted value ranges
`define DTP_OL_LEVEL_MIN   16'h07d0
`define DTP_OL_LEVEL_MAX   16'h3a98
`define DTP_DECEL_MIN      16'h0001
`define DTP_DECEL_MAX      16'h012c
`define DTP_GAIN_MAX       16'h00ff
`define DTP_START_MIN      16'h0005
`define DTP_START_MAX      16'h0063
`define DTP_CARRIER_MIN    16'h0014
`define DTP_CARRIER_MAX    16'h008c
`define DTP_SCALE_MIN      16'h0001
`define DTP_SCALE_MAX      16'h03e7
`define DTP_RATIO_MAX      16'h03e8
`define DTP_BRK_LV_MIN     16'h014a
`define DTP_BRK_LV_MAX     16'h017c
`define DTP_BRK_HV_MIN     16'h0294
`define DTP_BRK_HV_MAX     16'h02f8
`define DTP_REGION_MAX     16'h0003
// ==========================================================================
// Reset values
`define DTP_RST_OL_MODE    16'h0001
`define DTP_RST_OL_LEVEL   16'h2ee0
`define DTP_RST_OL_DECEL   16'h000a
`define DTP_RST_AM_GAIN    16'h0064
`define DTP_RST_START_FRQ  16'h0005
`define DTP_RST_CARRIER    16'h0032
`define DTP_RST_SCALE      16'h000a
`define DTP_RST_BRK_LEVEL  16'h0168
// ==========================================================================
// Timing
`define DTP_CLK_HZ         125000000
`define DTP_FAN_DELAY_MIN  5
`define DTP_FAN_DELAY_S    (`DTP_FAN_DELAY_MIN * 60)
`endif

// ---- rtl/dtp_pkg.sv ----
// Types shared by the drive tuning parameter bank
package dtp_pkg;
   // ========================================================================
   // Data word, fan stop-delay states and word index
   typedef logic [15:0] dtp_word_t;
   typedef enum logic [1:0] {
      DTP_FAN_RUN  = 2'b00,  // Drive running; delay count held at zero
      DTP_FAN_HOLD = 2'b01,  // Stopped, counting up the delay
      DTP_FAN_OFF  = 2'b10   // Delay expired
   } dtp_fan_e;
   typedef logic [4:0] dtp_idx_t;
endpackage

// ---- rtl/dtp_sync2.sv ----
// Two-stage synchroniser for one pin level
`timescale 1ns/100ps
module dtp_sync2 (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level_q
);
   logic meta_q;  // First stage, read only by the second
   // ========================================================================
   // Two flops; the first may go metastable
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         meta_q  <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         meta_q  <= pin;
         level_q <= meta_q;
      end
   end
endmodule // dtp_sync2

// ---- rtl/dtp_sec_tick.sv ----
// Divider that yields a one-cycle enable once per second
`timescale 1ns/100ps
`include "dtp_map.svh"
module dtp_sec_tick #(
   parameter int SEC_CYCLES = `DTP_CLK_HZ
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   output logic      tick_q
);
   logic [31:0] cnt_q;  // Cycles within the current second
   initial
   begin
      if (SEC_CYCLES < 2)
         $error("SEC_CYCLES must be at least 2");
   end
   // ========================================================================
   // Free running count, pulse on wrap
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (cnt_q == 32'(SEC_CYCLES - 1));
         cnt_q  <= (cnt_q == 32'(SEC_CYCLES - 1)) ? 32'h0 : cnt_q + 32'h1;
      end
   end
endmodule // dtp_sec_tick

// ---- rtl/dtp_param_bank.sv ----
// Drive fine tuning holding registers with range and lock checks
`timescale 1ns/100ps
`include "dtp_map.svh"
module dtp_param_bank
   import dtp_pkg::*;
#(
   parameter int SEC_CYCLES = `DTP_CLK_HZ,  // Cycles per second tick
   parameter int AM_W       = 10,           // Analog monitor code width
   parameter int FRQ_W      = 16            // Frequency monitor width
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               net_wr_stb,
   input  wire logic               net_rd_stb,
   input  wire dtp_pkg::dtp_word_t net_addr,
   input  wire dtp_pkg::dtp_word_t net_wdata,
   output dtp_pkg::dtp_word_t      net_rdata_q,
   output logic                    net_ack_q,
   output logic                    net_err_q,
   input  wire logic               kp_region_we,
   input  wire dtp_pkg::dtp_word_t kp_region_val,
   input  wire logic               lock_input_terminal,
   input  wire logic               high_volt_model,
   input  wire logic               fan_hot,
   input  wire logic               drive_running,
   input  wire logic               kp_stop,
   input  wire logic               init_go,
   input  wire logic [AM_W-1:0]    am_level,
   input  wire logic [FRQ_W-1:0]   out_freq,
   output logic [AM_W-1:0]         analog_monitor_output_q,
   output logic [FRQ_W+9:0]        scaled_frequency_monitor_q,
   output logic                    ol_limit_accel_q,
   output logic                    ol_limit_const_q,
   output logic                    freq_set_ok_q,
   output logic                    stop_cmd_q,
   output logic                    restart_match_q,
   output logic                    coast_stop_q,
   output logic                    fan_on_q,
   output logic                    brake_on_q,
   output logic                    clear_trips_q,
   output logic                    load_defaults_q,
   output dtp_pkg::dtp_word_t      ol_level_q,
   output dtp_pkg::dtp_word_t      ol_decel_q,
   output dtp_pkg::dtp_word_t      start_freq_q,
   output dtp_pkg::dtp_word_t      carrier_q,
   output dtp_pkg::dtp_word_t      brake_ratio_q,
   output dtp_pkg::dtp_word_t      brake_level_q,
   output dtp_pkg::dtp_word_t      region_q
);
   import dtp_pkg::*;

   localparam int NREG = 18;  // Words from first to last offset
   initial
   begin
      if (AM_W < 1 || AM_W > 16 || FRQ_W < 1 || FRQ_W > 22)
         $error("Unsupported monitor widths");
   end

   // ========================================================================
   // Storage and decode
   dtp_word_t regs_q [NREG];  // Holding words, index = offset - first
   dtp_word_t idx_full;       // Offset relative to first word
   dtp_idx_t  idx;            // Word index
   logic      mapped;         // Address falls inside the bank
   logic      lock_s;         // Synchronised lock terminal
   logic      hv_s;           // Synchronised model strap
   logic      hot_s;          // Synchronised fan thermostat
   logic      locked;         // Parameter changes are blocked
   logic      wr_ok;          // Network write will be stored
   logic      sec_tick;       // One pulse per second
   dtp_fan_e  fan_st_q;       // Fan stop-delay state
   logic [8:0] fan_cnt_q;     // Seconds since the drive stopped
   logic [31:0] lim_w;        // {low,high} limit of the addressed word

   assign idx_full = net_addr - `DTP_OFS_FIRST;
   assign idx      = idx_full[4:0];
   assign mapped   = (net_addr >= `DTP_OFS_FIRST) && (net_addr <= `DTP_OFS_LAST);

   // Returns {low,high} limit of a word; reserved and region are never written from the network
   function automatic logic [31:0] lim(input dtp_idx_t i, input logic hv);
      logic [31:0] r;
      r = 32'h0;
      unique case (i)
         5'd0, 5'd8, 5'd15, 5'd16: r = {16'h0, 16'h0002};
         5'd1:  r = {`DTP_OL_LEVEL_MIN, `DTP_OL_LEVEL_MAX};
         5'd2:  r = {`DTP_DECEL_MIN, `DTP_DECEL_MAX};
         5'd3:  r = {16'h0, 16'h0003};
         5'd4:  r = {16'h0, `DTP_GAIN_MAX};
         5'd6:  r = {`DTP_START_MIN, `DTP_START_MAX};
         5'd7:  r = {`DTP_CARRIER_MIN, `DTP_CARRIER_MAX};
         5'd10: r = {`DTP_SCALE_MIN, `DTP_SCALE_MAX};
         5'd11, 5'd12, 5'd14: r = {16'h0, 16'h0001};
         5'd13: r = {16'h0, `DTP_RATIO_MAX};
         5'd17: r = hv ? {`DTP_BRK_HV_MIN, `DTP_BRK_HV_MAX}
                       : {`DTP_BRK_LV_MIN, `DTP_BRK_LV_MAX};
         default: r = 32'h0000_ffff;  // Reserved and region; gated elsewhere
      endcase
      return r;
   endfunction

   // Reset and default value of each word
   function automatic dtp_word_t rst_val(input dtp_idx_t i);
      dtp_word_t v;
      v = 16'h0;
      unique case (i)
         5'd0:  v = `DTP_RST_OL_MODE;
         5'd1:  v = `DTP_RST_OL_LEVEL;
         5'd2:  v = `DTP_RST_OL_DECEL;
         5'd4:  v = `DTP_RST_AM_GAIN;
         5'd6:  v = `DTP_RST_START_FRQ;
         5'd7:  v = `DTP_RST_CARRIER;
         5'd10: v = `DTP_RST_SCALE;
         5'd17: v = `DTP_RST_BRK_LEVEL;
         default: v = 16'h0;
      endcase
      return v;
   endfunction

   // ========================================================================
   // Pin synchronisers and second divider
   dtp_sync2 u_sync_lock (.ref_clk(ref_clk), .rst(rst), .pin(lock_input_terminal),
                          .level_q(lock_s));
   dtp_sync2 u_sync_hv   (.ref_clk(ref_clk), .rst(rst), .pin(high_volt_model),
                          .level_q(hv_s));
   dtp_sync2 u_sync_hot  (.ref_clk(ref_clk), .rst(rst), .pin(fan_hot),
                          .level_q(hot_s));
   dtp_sec_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (.ref_clk(ref_clk), .rst(rst),
                                                   .tick_q(sec_tick));

   // ========================================================================
   // Write lock and acceptance
   // Codes 0/1 follow the terminal, 2/3 lock unconditionally
   assign locked = regs_q[3][1] || lock_s;
   // Lock word itself is always writable; ranges checked on the raw word
   assign lim_w = lim(idx, hv_s);
   assign wr_ok = mapped && idx != 5'd5 && idx != 5'd9
                  && (idx == 5'd3 || !locked)
                  && net_wdata >= lim_w[31:16]
                  && net_wdata <= lim_w[15:0];

   // ========================================================================
   // Register storage: reset, default load, network and keypad writes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NREG; i++)
            regs_q[i] <= rst_val(5'(i));
      end
      else if (load_defaults_q)
      begin
         // Region survives a default load; the loaded values do not depend on it
         for (int i = 0; i < NREG; i++)
            if (i != 9)
               regs_q[i] <= rst_val(5'(i));
      end
      else
      begin
         if (net_wr_stb && wr_ok)
            regs_q[idx] <= net_wdata;
         if (kp_region_we && kp_region_val <= `DTP_REGION_MAX)
            regs_q[9] <= kp_region_val;
      end
   end

   // ========================================================================
   // Network answer: one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         net_ack_q   <= 1'b0;
         net_err_q   <= 1'b0;
         net_rdata_q <= 16'h0;
      end
      else
      begin
         net_ack_q <= net_wr_stb || net_rd_stb;
         net_err_q <= net_wr_stb ? !wr_ok : (net_rd_stb && !mapped);
         if (net_rd_stb)
            // Reserved word has no storage behind it
            net_rdata_q <= (mapped && idx != 5'd5) ? regs_q[idx] : 16'h0;
      end
   end

   // ========================================================================
   // Option decodes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ol_limit_accel_q <= 1'b0;
         ol_limit_const_q <= 1'b0;
         freq_set_ok_q    <= 1'b0;
         stop_cmd_q       <= 1'b0;
         restart_match_q  <= 1'b0;
         coast_stop_q     <= 1'b0;
         brake_on_q       <= 1'b0;
      end
      else
      begin
         ol_limit_accel_q <= regs_q[0] == 16'h1;
         ol_limit_const_q <= regs_q[0] == 16'h1 || regs_q[0] == 16'h2;
         freq_set_ok_q    <= !locked || regs_q[3][0];
         stop_cmd_q       <= kp_stop && regs_q[11] == 16'h0;
         restart_match_q  <= regs_q[12] == 16'h1;
         coast_stop_q     <= regs_q[14] == 16'h1;
         // Zero ratio overrides any control code
         brake_on_q <= regs_q[13] != 16'h0 && (regs_q[16] == 16'h2
                       || (regs_q[16] == 16'h1 && drive_running));
      end
   end

   // ========================================================================
   // Initialisation pulses, one cycle per request
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         clear_trips_q   <= 1'b0;
         load_defaults_q <= 1'b0;
      end
      else
      begin
         clear_trips_q   <= init_go && regs_q[8] != 16'h1;
         load_defaults_q <= init_go && regs_q[8] != 16'h0;
      end
   end

   // ========================================================================
   // Monitor scaling; wide products kept whole then cut on purpose
   always_ff @(posedge ref_clk)
   begin
      logic [AM_W+7:0] am_p;
      am_p = (AM_W+8)'(am_level) * (AM_W+8)'(regs_q[4][7:0]);
      if (rst)
      begin
         analog_monitor_output_q    <= '0;
         scaled_frequency_monitor_q <= '0;
      end
      else
      begin
         // Gain 255 is close to unity; full scale at AM_W = 10 loses four codes
         analog_monitor_output_q    <= am_p[AM_W+7:8];
         scaled_frequency_monitor_q <= (FRQ_W+10)'(out_freq) * regs_q[10][9:0];
      end
   end

   // ========================================================================
   // Fan stop delay: count seconds after the drive stops
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fan_st_q  <= DTP_FAN_RUN;
         fan_cnt_q <= 9'h0;
      end
      else
      begin
         unique case (fan_st_q)
            DTP_FAN_RUN:
            begin
               fan_cnt_q <= 9'h0;
               if (!drive_running)
                  fan_st_q <= DTP_FAN_HOLD;
            end
            DTP_FAN_HOLD:
            begin
               if (drive_running)
                  fan_st_q <= DTP_FAN_RUN;
               else if (fan_cnt_q == 9'(`DTP_FAN_DELAY_S))
                  fan_st_q <= DTP_FAN_OFF;
               else if (sec_tick)
                  fan_cnt_q <= fan_cnt_q + 9'h1;
            end
            DTP_FAN_OFF:
            begin
               if (drive_running)
                  fan_st_q <= DTP_FAN_RUN;
            end
            default:
               fan_st_q <= DTP_FAN_RUN;
         endcase
      end
   end

   // Fan output by policy
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         fan_on_q <= 1'b1;
      else
         fan_on_q <= regs_q[15] == 16'h0
                     || (regs_q[15] == 16'h1 && (drive_running || fan_st_q != DTP_FAN_OFF))
                     || (regs_q[15] == 16'h2 && hot_s);
   end

   // ========================================================================
   // Word outputs straight from storage
   assign ol_level_q    = regs_q[1];
   assign ol_decel_q    = regs_q[2];
   assign start_freq_q  = regs_q[6];
   assign carrier_q     = regs_q[7];
   assign brake_ratio_q = regs_q[13];
   assign brake_level_q = regs_q[17];
   assign region_q      = regs_q[9];

   // ========================================================================
   // Checks
   rsvd_reads_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      net_rd_stb && net_addr == `DTP_OFS_RESERVED |=> net_ack_q && net_rdata_q == 16'h0)
      else $error("Reserved word read not zero");
   level_range_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      net_wr_stb && net_addr == `DTP_OFS_OL_LEVEL && net_wdata > `DTP_OL_LEVEL_MAX
      && !load_defaults_q |=> net_err_q && $stable(ol_level_q))
      else $error("Out of range level stored");
   hard_lock_blocks_a: assert property (@(posedge ref_clk) disable iff (rst)
      net_wr_stb && regs_q[3][1] && mapped && net_addr != `DTP_OFS_LOCK_SEL |=> net_err_q)
      else $error("Write passed a hard lock");
   term_lock_blocks_a: assert property (@(posedge ref_clk) disable iff (rst)
      net_wr_stb && regs_q[3] == 16'h0 && lock_s && net_addr == `DTP_OFS_CARRIER
      |=> net_err_q)
      else $error("Write passed terminal lock");
   region_net_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
      net_wr_stb && net_addr == `DTP_OFS_REGION && !kp_region_we && !load_defaults_q
      |=> net_err_q && $stable(region_q))
      else $error("Network changed region");
   brake_ratio_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      brake_ratio_q == 16'h0 |=> !brake_on_q)
      else $error("Braking with zero ratio");
   fan_always_on_a: assert property (@(posedge ref_clk) disable iff (rst)
      regs_q[15] == 16'h0 |=> fan_on_q)
      else $error("Fan off in always-on mode");
   stop_key_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      regs_q[11] == 16'h1 |=> !stop_cmd_q)
      else $error("Disabled stop key honoured");
   ol_const_only_a: assert property (@(posedge ref_clk) disable iff (rst)
      regs_q[0] == 16'h2 |=> ol_limit_const_q && !ol_limit_accel_q)
      else $error("Overload mode decode wrong");
   init_both_a: assert property (@(posedge ref_clk) disable iff (rst)
      init_go && regs_q[8] == 16'h2 |=> clear_trips_q && load_defaults_q)
      else $error("Init both not issued");
endmodule // dtp_param_bank

// ---- tb/dtp_net_master.sv ----
// Network master model issuing holding register requests
`timescale 1ns/100ps
module dtp_net_master
   import dtp_pkg::*;
(
   input  wire logic               ref_clk,
   output logic                    wr_stb,
   output logic                    rd_stb,
   output dtp_pkg::dtp_word_t      addr,
   output dtp_pkg::dtp_word_t      wdata,
   input  wire dtp_pkg::dtp_word_t rdata,
   input  wire logic               ack,
   input  wire logic               err
);
   // ======================================================================
   // Idle bus at time zero
   initial
   begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr   = 16'h0;
      wdata  = 16'h0;
   end
   // ======================================================================
   // One request: raised after a falling edge, taken at the next rising
   // edge; the answer stands one cycle, so it is read at the next fall
   task automatic xfer(input logic w, input dtp_pkg::dtp_word_t a, d,
                       output dtp_pkg::dtp_word_t q, output logic e, k);
      @(negedge ref_clk);
      wr_stb = w;
      rd_stb = !w;
      addr   = a;
      wdata  = d;
      @(negedge ref_clk);
      k      = ack;
      e      = err;
      q      = rdata;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      // Released lines flip, so a stale address never looks valid
      addr   = ~a;
      wdata  = ~d;
   endtask
endmodule // dtp_net_master

// ---- tb/drive_tuning_param_bank_test.sv ----
// Self-checking bench for the drive tuning parameter bank
`timescale 1ns/100ps
module drive_tuning_param_bank_test;
   import dtp_pkg::*;
   // ======================================================================
   // Pins, outputs and counters
   logic        ref_clk, rst, net_wr_stb, net_rd_stb, net_ack_q, net_err_q, kp_stop;
   logic        kp_region_we, lock_input_terminal, fan_hot, drive_running, init_go;
   logic        ol_limit_accel_q, ol_limit_const_q, freq_set_ok_q, stop_cmd_q;
   logic        restart_match_q, coast_stop_q, fan_on_q, brake_on_q;
   logic        clear_trips_q, load_defaults_q, high_volt_model;
   logic [9:0]  am_level, analog_monitor_output_q;
   logic [15:0] out_freq;
   logic [25:0] scaled_frequency_monitor_q;
   dtp_word_t   net_addr, net_wdata, net_rdata_q, kp_region_val, ol_level_q, region_q, a, v, w;
   dtp_word_t   ol_decel_q, start_freq_q, carrier_q, brake_ratio_q, brake_level_q;
   int          fails, samples_checked;
   // Accepted range and reset value of each word, 0x92 upward
   dtp_word_t lo[18] = '{16'h0, 16'h7d0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h5, 16'h14, 16'h0,
      16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h14a};
   dtp_word_t hi[18] = '{16'h2, 16'h3a98, 16'h12c, 16'h3, 16'hff, 16'h0, 16'h63, 16'h8c,
      16'h2, 16'h3, 16'h3e7, 16'h1, 16'h1, 16'h3e8, 16'h1, 16'h2, 16'h2, 16'h17c};
   dtp_word_t rv[18] = '{16'h1, 16'h2ee0, 16'ha, 16'h0, 16'h64, 16'h0, 16'h5, 16'h32, 16'h0,
      16'h0, 16'ha, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h168};
   // ======================================================================
   // Design, partner and clock; short second tick keeps the fan delay small
   dtp_param_bank #(.SEC_CYCLES(4)) dut (.ref_clk, .rst, .net_wr_stb, .net_rd_stb,
      .net_addr, .net_wdata, .net_rdata_q, .net_ack_q, .net_err_q, .kp_region_we,
      .kp_region_val, .lock_input_terminal, .high_volt_model, .fan_hot,
      .drive_running, .kp_stop, .init_go, .am_level, .out_freq, .analog_monitor_output_q,
      .scaled_frequency_monitor_q, .ol_limit_accel_q, .ol_limit_const_q, .freq_set_ok_q,
      .stop_cmd_q, .restart_match_q, .coast_stop_q, .fan_on_q, .brake_on_q, .clear_trips_q,
      .load_defaults_q, .ol_level_q, .ol_decel_q, .start_freq_q, .carrier_q,
      .brake_ratio_q, .brake_level_q, .region_q);
   dtp_net_master u_m (.ref_clk, .wr_stb(net_wr_stb), .rd_stb(net_rd_stb), .addr(net_addr),
      .wdata(net_wdata), .rdata(net_rdata_q), .ack(net_ack_q), .err(net_err_q));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ======================================================================
   // Compare, access and reporting tasks
   task automatic chk_w(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch t=%0t flag %b exp %b", $time, g, e);
      end
   endtask
   // Write or read; a read that is not refused must return d
   task automatic io(input logic wr, input dtp_word_t ad, d, input logic e);
      dtp_word_t q;
      logic      r, k;
      u_m.xfer(wr, ad, d, q, r, k);
      chk_b(k, 1'b1);
      chk_b(r, e);
      if (!wr && !e)
         chk_w(q, d);
   endtask
   // Decoded outputs trail the word and the synchronisers by a few edges
   task settle;
      repeat (4) @(negedge ref_clk);
   endtask
   task wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ======================================================================
   // Watchdog: the tests need some 1800 cycles, this allows 12500
   initial
   begin
      #100000;
      fails++;
      wrap_up;
   end
   // ======================================================================
   // Main sequence
   initial
   begin
      {rst, kp_region_we, lock_input_terminal, fan_hot, drive_running, kp_stop} = 6'h21;
      {init_go, high_volt_model, am_level, out_freq, kp_region_val} = 44'h0;
      fails = 0;
      samples_checked = 0;
      void'($urandom(26));
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      // Reset values, then every range edge and a random legal value
      for (int i = 0; i < 18; i++)
         io(1'b0, 16'h92 + 16'(i), rv[i], 1'b0);
      io(1'b0, 16'h91, 16'h0, 1'b1);
      for (int i = 0; i < 18; i++)
      begin
         a = 16'h92 + 16'(i);
         if (i == 5 || i == 9)
            io(1'b1, a, 16'h1, 1'b1);
         else
         begin
            if (lo[i] != 16'h0)
               io(1'b1, a, lo[i] - 16'h1, 1'b0 + 1'b1);
            io(1'b1, a, hi[i] + 16'h1, 1'b1);
            io(1'b0, a, rv[i], 1'b0);
            v = lo[i] + 16'($urandom_range(hi[i] - lo[i]));
            io(1'b1, a, v, 1'b0);
            io(1'b0, a, v, 1'b0);
            io(1'b1, a, lo[i], 1'b0);
            io(1'b1, a, hi[i], 1'b0);
            io(1'b0, a, hi[i], 1'b0);
            io(1'b1, a, rv[i], 1'b0);
         end
      end
      // Word ports show the stored words
      chk_w({ol_decel_q, start_freq_q}, {rv[2], rv[6]});
      chk_w({carrier_q, brake_ratio_q}, {rv[7], rv[13]});
      chk_w(brake_level_q, rv[17]);
      // Higher-voltage strap moves the brake level window
      high_volt_model = 1'b1;
      settle;
      io(1'b1, 16'ha3, 16'h17c, 1'b1);
      io(1'b1, 16'ha3, 16'h2f9, 1'b1);
      io(1'b1, 16'ha3, 16'h294, 1'b0);
      io(1'b0, 16'ha3, 16'h294, 1'b0);
      high_volt_model = 1'b0;
      $display("test ranges done");
      // Every option code of the decoded words
      io(1'b1, 16'h9f, 16'h64, 1'b0);
      for (int c = 0; c < 3; c++)
      begin
         foreach (lo[i])
            if (i == 0 || i == 15 || i == 16 || (c < 2 && (i == 11 || i == 12 || i == 14)))
               io(1'b1, 16'h92 + 16'(i), 16'(c), 1'b0);
         drive_running = 1'($urandom);
         fan_hot = 1'($urandom);
         kp_stop = 1'($urandom);
         settle;
         chk_b(ol_limit_accel_q, c == 1);
         chk_b(ol_limit_const_q, c != 0);
         chk_b(brake_on_q, c == 2 || (c == 1 && drive_running));
         chk_b(fan_on_q, c != 2 || fan_hot);
         if (c < 2)
         begin
            chk_b(stop_cmd_q, kp_stop && c == 0);
            chk_b(restart_match_q, c == 1);
            chk_b(coast_stop_q, c == 1);
         end
      end
      io(1'b1, 16'h9f, 16'h0, 1'b0);
      settle;
      chk_b(brake_on_q, 1'b0);
      $display("test codes done");
      // Lock by pin, then regardless of the pin
      lock_input_terminal = 1'b1;
      settle;
      io(1'b1, 16'h93, 16'hbb8, 1'b1);
      chk_b(freq_set_ok_q, 1'b0);
      io(1'b1, 16'h95, 16'h1, 1'b0);
      settle;
      chk_b(freq_set_ok_q, 1'b1);
      lock_input_terminal = 1'b0;
      for (int c = 2; c < 4; c++)
      begin
         io(1'b1, 16'h95, 16'(c), 1'b0);
         io(1'b1, 16'h93, 16'hbb8, 1'b1);
         settle;
         chk_b(freq_set_ok_q, c == 3);
      end
      io(1'b1, 16'h95, 16'h0, 1'b0);
      $display("test lock done");
      // Region word: network refused, keypad accepted
      io(1'b1, 16'h9b, 16'h1, 1'b1);
      kp_region_val = 16'($urandom_range(3));
      kp_region_we = 1'b1;
      @(negedge ref_clk);
      kp_region_we = 1'b0;
      chk_w(region_q, kp_region_val);
      io(1'b0, 16'h9b, kp_region_val, 1'b0);
      // Monitor gain and display scale with random operands
      repeat (8)
      begin
         v = 16'($urandom_range(255));
         w = 16'($urandom_range(998)) + 16'h1;
         io(1'b1, 16'h96, v, 1'b0);
         io(1'b1, 16'h9c, w, 1'b0);
         am_level = 10'($urandom);
         out_freq = 16'($urandom);
         settle;
         chk_w(32'(analog_monitor_output_q), (32'(am_level) * v) >> 8);
         chk_w(32'(scaled_frequency_monitor_q), 32'(out_freq) * w);
      end
      $display("test monitors done");
      // Initialisation of each kind; region survives defaults
      for (int m = 0; m < 3; m++)
      begin
         io(1'b1, 16'h93, 16'hbb8, 1'b0);
         io(1'b1, 16'h9a, 16'(m), 1'b0);
         init_go = 1'b1;
         @(negedge ref_clk);
         init_go = 1'b0;
         chk_b(clear_trips_q, m != 1);
         chk_b(load_defaults_q, m != 0);
         @(negedge ref_clk);
         chk_w(ol_level_q, (m != 0) ? 16'h2ee0 : 16'hbb8);
      end
      chk_w(region_q, kp_region_val);
      $display("test init done");
      // Fan in run mode: stays on through the stop delay, then off
      io(1'b1, 16'ha1, 16'h1, 1'b0);
      drive_running = 1'b1;
      settle;
      drive_running = 1'b0;
      repeat (1100) @(negedge ref_clk);
      chk_b(fan_on_q, 1'b1);
      repeat (200) @(negedge ref_clk);
      chk_b(fan_on_q, 1'b0);
      $display("test fan done");
      wrap_up;
   end
endmodule // drive_tuning_param_bank_test
